// ==== hw/acc_pkg.sv ====
/*
 * constants shared by the converter control block: register field
 * positions, written codes, input-select codes and conversion timing.
 * assumes register bytes arrive as plain ports with no bus decode.
 */
package acc_pkg;

    // first control byte
    localparam int unsigned ENABLE_BIT      = 5;
    localparam int unsigned CHAN_SEL_LSB    = 0;
    localparam int unsigned CHAN_SEL_W      = 4;

    // clock and input control byte
    localparam int unsigned CLK_SEL_LSB     = 0;
    localparam int unsigned CLK_SEL_W       = 3;
    localparam int unsigned SRC_SEL_LSB     = 4;
    localparam int unsigned SRC_SEL_W       = 4;

    // reference control byte
    localparam int unsigned REF_SEL_LSB     = 0;
    localparam int unsigned REF_SEL_W       = 2;

    // port a pin-function select byte: field for the channel-zero pin
    localparam int unsigned PIN_FN_LSB      = 6;
    localparam int unsigned PIN_FN_W        = 2;
    localparam logic [1:0]  PIN_FN_ANALOG   = 2'h1;

    // input source codes
    localparam logic [3:0]  SRC_EXT_A       = 4'h0;
    localparam logic [3:0]  SRC_EXT_B       = 4'h4;
    localparam logic [3:0]  SRC_EXT_C_LO    = 4'hc;
    localparam logic [3:0]  SRC_AMP_FIRST   = 4'h8;
    localparam logic [3:0]  SRC_AMP_SECOND  = 4'h9;

    // result and timing
    localparam int unsigned RES_W           = 12;
    localparam logic [11:0] RES_MSB_MASK    = 12'h800;
    localparam int unsigned SAMPLE_TICKS    = 4;
    localparam int unsigned CONVERT_TICKS   = 12;
    localparam int unsigned TOTAL_TICKS     = SAMPLE_TICKS + CONVERT_TICKS;
    localparam int unsigned DIV_W           = 7;

    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_ARMED,
        ACC_SAMPLE,
        ACC_CONVERT
    } acc_state_e;

endpackage

// ==== hw/acc_tick_gen.sv ====
/*
 * conversion clock enable: one-cycle pulse every 2^sel system clocks.
 * assumes the caller restarts it to align the phase with a conversion.
 */
`timescale 1ns/1ps

module acc_tick_gen #(
    parameter int unsigned DIV_W = 7
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    // control
    input  wire logic             restart,
    input  wire logic [2:0]       div_sel,
    // enable out
    output logic                  tick
);

    logic [DIV_W-1:0] cnt_ff;
    logic [DIV_W-1:0] div_mask;
    logic             tick_ff;

    // low bits all ones mark the end of one divided period
    assign div_mask = DIV_W'((8'h01 << div_sel) - 8'h01);
    assign tick     = tick_ff;

    // free running counter, cleared so a conversion starts on a full period
    always_ff @(posedge core_clk)
    begin
        if (!rst_b || restart)
            cnt_ff <= '0;
        else
            cnt_ff <= cnt_ff + DIV_W'(1);
    end

    // pulse register
    always_ff @(posedge core_clk)
    begin
        if (!rst_b || restart)
            tick_ff <= 1'b0;
        else
            tick_ff <= ((cnt_ff & div_mask) == div_mask);
    end

endmodule

// ==== hw/acc_adc_ctrl.sv ====
/*
 * control logic of a 12-bit successive-approximation converter: power,
 * input routing, start sequence, sample/convert timing, busy, interrupt
 * flag and result bytes.
 * assumes register bytes are plain ports held by the cpu side, a
 * comparator bit from the analog core, and one 200 MHz clock.
 */
`timescale 1ns/1ps

// Operation
// R01 - clearing the enable bit powers down every converter circuit
// R02 - result is 12-bit unsigned, full scale all ones, step of vref/4096
// R03 - start low-high-low: high resets converter, falling edge begins conversion
// R04 - busy flag high during conversion, cleared at completion, pollable
// R05 - completion sets the interrupt flag; software clears it and enables interrupts
// R06 - result read as a low byte and a high byte
// R07 - clock control value 03h selects system clock divided by eight
// R08 - 20h first control, 00h reference control: enabled, channel zero
// R09 - pin-function value 40h switches pin to analog channel zero
// R10 - both proximity amplifier outputs selectable as internal converter inputs
// R11 - codes 1000 and 1001 route first and second amplifier, external off
// R12 - conversion takes 16 clock periods: 4 sampling then 12 converting
// R13 - result holds until next completion; one interrupt per conversion
module acc_adc_ctrl (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // register bytes from software
    input  wire logic [7:0]  converter_control_first,
    input  wire logic [7:0]  converter_clock_input_control,
    input  wire logic [7:0]  converter_reference_control,
    input  wire logic [7:0]  porta_pin_function_select,
    input  wire logic        start_bit,
    input  wire logic        conversion_irq_enable,
    input  wire logic        global_irq_enable,
    input  wire logic        conversion_irq_flag_clr,
    // analog core feedback
    input  wire logic        cmp_above,
    // status and result
    output logic             conversion_busy_flag,
    output logic             conversion_irq_flag,
    output logic             conversion_irq_req,
    output logic [7:0]       result_low_byte,
    output logic [7:0]       result_high_byte,
    // analog core control
    output logic             analog_power_en,
    output logic             sample_en,
    output logic [11:0]      sar_trial_code,
    output logic [1:0]       reference_source_select,
    output logic             external_channel_zero_pin_en,
    output logic             ext_channel_connect,
    output logic [3:0]       ext_channel_sel,
    output logic [3:0]       internal_source_sel,
    output logic             first_stage_amp_route,
    output logic             second_stage_amp_route
);

    ////////////////////////////////////////////////////////////////////////
    // field decode

    logic       converter_power_enable;
    logic [2:0] conversion_clock_select;
    logic [3:0] input_source_select;
    logic [3:0] chan_sel;
    logic       src_external;

    assign converter_power_enable  = converter_control_first[acc_pkg::ENABLE_BIT];
    assign chan_sel                = converter_control_first[acc_pkg::CHAN_SEL_LSB
                                         +: acc_pkg::CHAN_SEL_W];
    assign conversion_clock_select = converter_clock_input_control[acc_pkg::CLK_SEL_LSB
                                         +: acc_pkg::CLK_SEL_W];
    assign input_source_select     = converter_clock_input_control[acc_pkg::SRC_SEL_LSB
                                         +: acc_pkg::SRC_SEL_W];
    // external codes; every other code is an internal source and wins
    assign src_external = (input_source_select == acc_pkg::SRC_EXT_A)
                       || (input_source_select == acc_pkg::SRC_EXT_B)
                       || (input_source_select >= acc_pkg::SRC_EXT_C_LO);

    ////////////////////////////////////////////////////////////////////////
    // start edges and clock enable

    logic start_d_ff;
    logic start_rise;
    logic start_fall;
    logic tick;

    assign start_rise = start_bit && !start_d_ff;
    assign start_fall = !start_bit && start_d_ff;

    // previous start level for edge detection
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            start_d_ff <= 1'b0;
        else
            start_d_ff <= start_bit;
    end

    // R07 divide by 2^select, so 3 gives system clock over eight
    acc_tick_gen #(
        .DIV_W    (acc_pkg::DIV_W)
    ) u_tick (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .restart  (start_rise || start_fall || !converter_power_enable),
        .div_sel  (conversion_clock_select),
        .tick     (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // conversion sequencer

    acc_pkg::acc_state_e state_ff;
    logic [1:0]          samp_cnt_ff;
    logic [11:0]         trial_ff;
    logic [11:0]         mask_ff;
    logic [11:0]         nxt_kept;
    logic                done;

    // keep the trial bit only when the input sits at or above it
    assign nxt_kept = cmp_above ? trial_ff : (trial_ff & ~mask_ff);
    assign done     = (state_ff == acc_pkg::ACC_CONVERT) && tick && mask_ff[0];

    // R01 disable forces idle; R03 rise resets, fall launches
    always_ff @(posedge core_clk)
    begin
        if (!rst_b || !converter_power_enable)
            state_ff <= acc_pkg::ACC_IDLE;
        else if (start_rise)
            state_ff <= acc_pkg::ACC_ARMED;
        else if (start_fall && state_ff == acc_pkg::ACC_ARMED)
            state_ff <= acc_pkg::ACC_SAMPLE;
        else
        begin
            case (state_ff)
                acc_pkg::ACC_SAMPLE:
                    if (tick && samp_cnt_ff == 2'(acc_pkg::SAMPLE_TICKS - 1))
                        state_ff <= acc_pkg::ACC_CONVERT;
                acc_pkg::ACC_CONVERT:
                    if (done)
                        state_ff <= acc_pkg::ACC_IDLE;
                default:
                    state_ff <= state_ff;
            endcase
        end
    end

    // R12 four sampling periods counted here
    always_ff @(posedge core_clk)
    begin
        if (!rst_b || state_ff != acc_pkg::ACC_SAMPLE)
            samp_cnt_ff <= '0;
        else if (tick)
            samp_cnt_ff <= samp_cnt_ff + 2'h1;
    end

    // R12 one bit decided per period, msb first, twelve periods
    always_ff @(posedge core_clk)
    begin
        if (!rst_b || state_ff == acc_pkg::ACC_SAMPLE)
        begin
            trial_ff <= acc_pkg::RES_MSB_MASK;
            mask_ff  <= acc_pkg::RES_MSB_MASK;
        end
        else if (state_ff == acc_pkg::ACC_CONVERT && tick && !mask_ff[0])
        begin
            trial_ff <= nxt_kept | (mask_ff >> 1);
            mask_ff  <= mask_ff >> 1;
        end
        else if (done)
            trial_ff <= nxt_kept;
    end

    ////////////////////////////////////////////////////////////////////////
    // status, result and interrupt

    logic        busy_ff;
    logic        irq_flag_ff;
    logic        irq_req_ff;
    logic [11:0] result_ff;

    // R04 busy from launch to completion, dropped by reset, disable or a start rise
    always_ff @(posedge core_clk)
    begin
        if (!rst_b || !converter_power_enable || start_rise || done)
            busy_ff <= 1'b0;
        else if (start_fall && state_ff == acc_pkg::ACC_ARMED)
            busy_ff <= 1'b1;
    end

    // R02 R13 unsigned 12-bit code kept until the next completion
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            result_ff <= '0;
        else if (done)
            result_ff <= nxt_kept;
    end

    // R05 set on completion wins over a software clear in the same cycle
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            irq_flag_ff <= 1'b0;
        else if (done)
            irq_flag_ff <= 1'b1;
        else if (conversion_irq_flag_clr)
            irq_flag_ff <= 1'b0;
    end

    // R05 request only with both enables set
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            irq_req_ff <= 1'b0;
        else
            irq_req_ff <= irq_flag_ff && conversion_irq_enable && global_irq_enable;
    end

    ////////////////////////////////////////////////////////////////////////
    // analog routing, registered so every output leaves a flop

    logic       power_ff;
    logic       sample_ff;
    logic [1:0] ref_ff;
    logic       pin_an_ff;
    logic       ext_conn_ff;
    logic [3:0] ext_sel_ff;
    logic [3:0] int_sel_ff;
    logic       amp0_ff;
    logic       amp1_ff;

    // R01 R08 R10 R11 internal source overrides external; power, sampling, external connect and amp routes off when disabled
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            power_ff    <= 1'b0;
            sample_ff   <= 1'b0;
            ref_ff      <= '0;
            ext_conn_ff <= 1'b0;
            ext_sel_ff  <= '0;
            int_sel_ff  <= '0;
            amp0_ff     <= 1'b0;
            amp1_ff     <= 1'b0;
        end
        else
        begin
            power_ff    <= converter_power_enable;
            sample_ff   <= converter_power_enable && (state_ff == acc_pkg::ACC_SAMPLE);
            ref_ff      <= converter_reference_control[acc_pkg::REF_SEL_LSB
                               +: acc_pkg::REF_SEL_W];
            ext_conn_ff <= converter_power_enable && src_external;
            ext_sel_ff  <= chan_sel;
            int_sel_ff  <= src_external ? 4'h0 : input_source_select;
            amp0_ff     <= converter_power_enable
                        && (input_source_select == acc_pkg::SRC_AMP_FIRST);
            amp1_ff     <= converter_power_enable
                        && (input_source_select == acc_pkg::SRC_AMP_SECOND);
        end
    end

    // R09 pin goes analog when its function field reads analog
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            pin_an_ff <= 1'b0;
        else
            pin_an_ff <= porta_pin_function_select[acc_pkg::PIN_FN_LSB
                             +: acc_pkg::PIN_FN_W] == acc_pkg::PIN_FN_ANALOG;
    end

    // R06 result split into two bytes, high byte zero-padded
    assign result_low_byte              = result_ff[7:0];
    assign result_high_byte             = {4'h0, result_ff[11:8]};
    assign conversion_busy_flag         = busy_ff;
    assign conversion_irq_flag          = irq_flag_ff;
    assign conversion_irq_req           = irq_req_ff;
    assign analog_power_en              = power_ff;
    assign sample_en                    = sample_ff;
    assign sar_trial_code               = trial_ff;
    assign reference_source_select      = ref_ff;
    assign external_channel_zero_pin_en = pin_an_ff;
    assign ext_channel_connect          = ext_conn_ff;
    assign ext_channel_sel              = ext_sel_ff;
    assign internal_source_sel          = int_sel_ff;
    assign first_stage_amp_route        = amp0_ff;
    assign second_stage_amp_route       = amp1_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic [4:0] tick_cnt_ff;

    // helper: periods seen since launch
    always_ff @(posedge core_clk)
    begin
        if (!rst_b || !busy_ff)
            tick_cnt_ff <= '0;
        else if (tick)
            tick_cnt_ff <= tick_cnt_ff + 5'h1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_power_down_off: assert property (!converter_power_enable |=> !analog_power_en && !busy_ff
        && !sample_en && !first_stage_amp_route) else $error("circuits on while disabled"); // R01
    a_result_full_scale: assert property (done |=> {result_high_byte, result_low_byte} // R02
        == {4'h0, sar_trial_code}) else $error("result bytes not the 12-bit code");
    a_start_rise_reset: assert property (start_rise |=> !busy_ff)
        else $error("start high did not reset"); // R03
    a_start_fall_launch: assert property (converter_power_enable && start_fall
        && state_ff == acc_pkg::ACC_ARMED |=> busy_ff && state_ff == acc_pkg::ACC_SAMPLE)
        else $error("falling start did not launch"); // R03
    a_busy_period_count: assert property (done |-> tick_cnt_ff == 5'(acc_pkg::TOTAL_TICKS - 1))
        else $error("conversion not sixteen periods"); // R12
    a_done_clears_busy: assert property (done |=> !busy_ff && irq_flag_ff)
        else $error("completion missed busy or flag"); // R04
    a_irq_request_gate: assert property (irq_flag_ff && conversion_irq_enable
        && global_irq_enable |=> conversion_irq_req) else $error("request not raised"); // R05
    a_result_hold: assert property (!done |=> $stable(result_ff))
        else $error("result changed without completion"); // R13
    a_amp_route_override: assert property (converter_power_enable
        && input_source_select == acc_pkg::SRC_AMP_SECOND |=> second_stage_amp_route
        && !ext_channel_connect) else $error("amplifier route wrong"); // R11
    a_pin_analog_fn: assert property (porta_pin_function_select == 8'h40
        |=> external_channel_zero_pin_en) else $error("pin not analog"); // R09

    c_full_conversion: cover property (done);
    c_abort_by_restart: cover property (busy_ff && start_rise);
    c_flag_set_clear: cover property (done && conversion_irq_flag_clr);
    c_amp_first_done: cover property (first_stage_amp_route && done);

endmodule

// ==== verification/acc_analog_model.sv ====
/*
 * behavioural analog core facing the converter control: input mux,
 * sample-and-hold and ideal comparator against the trial code.
 * assumes levels are given as 12-bit codes by the bench.
 */
`timescale 1ns/1ps

module acc_analog_model (
    // clock
    input  wire logic        core_clk,
    // control from the block
    input  wire logic        analog_power_en,
    input  wire logic        sample_en,
    input  wire logic [11:0] sar_trial_code,
    input  wire logic        external_channel_zero_pin_en,
    input  wire logic        ext_channel_connect,
    input  wire logic [3:0]  ext_channel_sel,
    input  wire logic        first_stage_amp_route,
    input  wire logic        second_stage_amp_route,
    // levels set by the bench
    input  wire logic [11:0] lvl_ext,
    input  wire logic [11:0] lvl_amp1,
    input  wire logic [11:0] lvl_amp2,
    // comparator
    output logic             cmp_above
);
    logic        noise_ff = 1'b0;
    logic [11:0] held_ff;
    logic [11:0] nxt_held;

    // floating or unpowered lines wander every cycle
    always_ff @(posedge core_clk)
        noise_ff <= ~noise_ff;

    // amplifier outputs win over the pin
    always_comb
    begin
        if (first_stage_amp_route)
            nxt_held = lvl_amp1;
        else if (second_stage_amp_route)
            nxt_held = lvl_amp2;
        else if (ext_channel_connect && ext_channel_sel == 4'h0 && external_channel_zero_pin_en)
            nxt_held = lvl_ext;
        else
            nxt_held = {12{noise_ff}};
    end

    // sample-and-hold tracks while sampling
    always_ff @(posedge core_clk)
        if (sample_en)
            held_ff <= nxt_held;

    assign cmp_above = analog_power_en ? (held_ff >= sar_trial_code) : noise_ff;
endmodule

// ==== verification/adc_conversion_control_bench.sv ====
/*
 * self-checking bench: routing table, then conversions, aborts, irq.
 * assumes the analog model as far side and a 200 MHz core clock.
 */
`timescale 1ns/1ps

module adc_conversion_control_bench;
    typedef struct packed {
        logic [7:0] first, ci, rf, pin;
        logic [14:0] exp;
    } acc_row_s;

    logic core_clk, rst_b, start_bit, irq_en, gie, flag_clr;
    logic [7:0] ctl_first, clk_in, ref_ctl, pin_fn;
    logic [11:0] lvl_ext, lvl_amp1, lvl_amp2, trial;
    logic cmp, busy, flag, req, pwr, smp, pin_en, conn, amp1, amp2;
    logic [7:0] res_lo, res_hi;
    logic [1:0] ref_out;
    logic [3:0] ext_sel, int_sel;
    int error_cnt, checks, n;
    acc_row_s rows [7];

    acc_adc_ctrl dut (.core_clk(core_clk), .rst_b(rst_b),
        .converter_control_first(ctl_first), .converter_clock_input_control(clk_in),
        .converter_reference_control(ref_ctl), .porta_pin_function_select(pin_fn),
        .start_bit(start_bit), .conversion_irq_enable(irq_en), .global_irq_enable(gie),
        .conversion_irq_flag_clr(flag_clr), .cmp_above(cmp),
        .conversion_busy_flag(busy), .conversion_irq_flag(flag), .conversion_irq_req(req),
        .result_low_byte(res_lo), .result_high_byte(res_hi), .analog_power_en(pwr),
        .sample_en(smp), .sar_trial_code(trial), .reference_source_select(ref_out),
        .external_channel_zero_pin_en(pin_en), .ext_channel_connect(conn),
        .ext_channel_sel(ext_sel), .internal_source_sel(int_sel),
        .first_stage_amp_route(amp1), .second_stage_amp_route(amp2));

    acc_analog_model far (.core_clk(core_clk), .analog_power_en(pwr), .sample_en(smp),
        .sar_trial_code(trial), .external_channel_zero_pin_en(pin_en),
        .ext_channel_connect(conn), .ext_channel_sel(ext_sel), .first_stage_amp_route(amp1),
        .second_stage_amp_route(amp2), .lvl_ext(lvl_ext), .lvl_amp1(lvl_amp1),
        .lvl_amp2(lvl_amp2), .cmp_above(cmp));

    ////////////////////////////////////////////////////////////////////////////////
    // clock
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask

    // settle past the edge before looking
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    // bounded wait; a hang ends the run
    task automatic wait_busy(input logic val, input int lim, output int cnt);
        cnt = 0;
        while (busy !== val)
        begin
            step(1);
            cnt++;
            if (cnt > lim)
            begin
                error_cnt++;
                $display("[ERR] %0t busy wait ran out", $time);
                close_out();
            end
        end
    endtask

    // rise resets, fall launches, flag cleared after start
    task automatic launch();
        @(posedge core_clk) start_bit <= 1'b1;
        @(posedge core_clk) start_bit <= 1'b0;
        flag_clr <= 1'b1;
        @(posedge core_clk) flag_clr <= 1'b0;
    endtask

    task automatic conv(input logic [2:0] sel, input logic [3:0] src,
                        input logic [11:0] want, input logic ie, input logic ge);
        int p;
        p = 1 << sel;
        @(posedge core_clk);
        ctl_first <= 8'h20;
        clk_in <= {src, 1'b0, sel};
        pin_fn <= 8'h40;
        irq_en <= ie;
        gie <= ge;
        step(3);
        launch();
        wait_busy(1'b1, 4, n);
        // sample-and-hold open right after launch
        check(32'(smp), 32'h1);
        wait_busy(1'b0, 16 * p + 8, n);
        check(32'(n >= 16 * p && n <= 16 * p + 4), 32'h1);
        step(2);
        check(32'({flag, req, res_hi, res_lo}), 32'({1'b1, ie & ge, 4'h0, want}));
        // last trial code left on the analog side is the result
        check(32'(trial), 32'(want));
        @(posedge core_clk) flag_clr <= 1'b1;
        @(posedge core_clk) flag_clr <= 1'b0;
        step(3);
        check(32'({flag, req}), 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_b = 1'b0; start_bit = 1'b0; irq_en = 1'b0; gie = 1'b0; flag_clr = 1'b0;
        ctl_first = 8'h00; clk_in = 8'h00; ref_ctl = 8'h00; pin_fn = 8'h00;
        lvl_ext = 12'h5a3; lvl_amp1 = 12'hfff; lvl_amp2 = 12'h000;
        error_cnt = 0; checks = 0;
        // exp = pwr conn ext_sel int_sel amp1 amp2 pin_en ref
        rows[0] = '{8'h20, 8'h03, 8'h00, 8'h40, {1'b1, 1'b1, 4'h0, 4'h0, 3'b001, 2'h0}};
        rows[1] = '{8'h20, 8'h80, 8'h01, 8'h00, {1'b1, 1'b0, 4'h0, 4'h8, 3'b100, 2'h1}};
        rows[2] = '{8'h23, 8'h90, 8'h02, 8'h80, {1'b1, 1'b0, 4'h3, 4'h9, 3'b010, 2'h2}};
        rows[3] = '{8'h00, 8'h00, 8'h03, 8'h00, {1'b0, 1'b0, 4'h0, 4'h0, 3'b000, 2'h3}};
        rows[4] = '{8'h27, 8'hc0, 8'h00, 8'h40, {1'b1, 1'b1, 4'h7, 4'h0, 3'b001, 2'h0}};
        rows[5] = '{8'h20, 8'h40, 8'h00, 8'h40, {1'b1, 1'b1, 4'h0, 4'h0, 3'b001, 2'h0}};
        rows[6] = '{8'h20, 8'ha0, 8'h00, 8'h40, {1'b1, 1'b0, 4'h0, 4'ha, 3'b001, 2'h0}};
        step(20);
        check(32'({busy, flag, req, pwr, res_hi, res_lo}), 32'h0);
        @(posedge core_clk) rst_b <= 1'b1;
        step(2);
        foreach (rows[i])
        begin
            @(posedge core_clk);
            ctl_first <= rows[i].first;
            clk_in <= rows[i].ci;
            ref_ctl <= rows[i].rf;
            pin_fn <= rows[i].pin;
            step(3);
            check(32'({pwr, conn, ext_sel, int_sel, amp1, amp2, pin_en, ref_out}),
                  32'(rows[i].exp));
        end
        @(posedge core_clk) ref_ctl <= 8'h00;
        conv(3'h3, 4'h0, 12'h5a3, 1'b0, 1'b0);
        conv(3'h0, 4'h8, 12'hfff, 1'b1, 1'b1);
        // start high aborts, old result kept, fall relaunches
        @(posedge core_clk) lvl_amp1 <= 12'h3c5;
        launch();
        wait_busy(1'b1, 4, n);
        step(10);
        @(posedge core_clk) start_bit <= 1'b1;
        wait_busy(1'b0, 4, n);
        check(32'({flag, res_hi, res_lo}), 32'({1'b0, 16'h0fff}));
        @(posedge core_clk) start_bit <= 1'b0;
        wait_busy(1'b1, 4, n);
        wait_busy(1'b0, 30, n);
        step(2);
        check(32'({flag, res_hi, res_lo}), 32'({1'b1, 16'h03c5}));
        // disable mid-run powers down with no flag
        launch();
        wait_busy(1'b1, 4, n);
        step(5);
        @(posedge core_clk) ctl_first <= 8'h00;
        wait_busy(1'b0, 4, n);
        step(2);
        check(32'({pwr, smp, flag, res_hi, res_lo}), 32'({3'b000, 16'h03c5}));
        // reset in mid-run drops busy, power, flag and the kept result
        @(posedge core_clk) ctl_first <= 8'h20;
        launch();
        wait_busy(1'b1, 4, n);
        @(posedge core_clk) rst_b <= 1'b0;
        step(2);
        check(32'({busy, flag, req, pwr, smp, res_hi, res_lo}), 32'h0);
        @(posedge core_clk) rst_b <= 1'b1;
        step(2);
        conv(3'h1, 4'h9, 12'h000, 1'b1, 1'b0);
        close_out();
    end
endmodule
